/* File: shared/ext_mon_params.svh */
// offsets, field positions, reset values and timing counts of the monitor supervisor
`ifndef EXT_MON_PARAMS_SVH
`define EXT_MON_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define EM_OFS_CTRL 6'h00
`define EM_OFS_STATUS 6'h04
`define EM_OFS_MASK 6'h08
`define EM_OFS_STATE 6'h0C
`define EM_OFS_CH0 6'h10

// ****************************************
// field positions
// ****************************************
`define EM_CTRL_IO_PROFILE 0
`define EM_CTRL_EXT_FITTED 1
`define EM_ERR_LSB 8
`define EM_STOP_BIT 16

// ****************************************
// source select codes
// ****************************************
`define EM_SRC_NONE 7'h00
`define EM_SRC_DI_HI 7'h01
`define EM_SRC_EXT_HI 7'h09
`define EM_SRC_DI_LO 7'h11
`define EM_SRC_EXT_LO 7'h19
`define EM_SRC_CW 7'h20
`define EM_CW_IO_ONLY_MAX 4'hA

// ****************************************
// reset values and timing
// ****************************************
`define EM_CTRL_RST 2'h0
`define EM_MASK_RST 32'h0000_0000
`define EM_DELAY_MAX 9'h12C
`define EM_CLK_HZ 125000000
`define EM_DELAY_UNIT_S 1
`define EM_TICK_CYCLES (`EM_CLK_HZ * `EM_DELAY_UNIT_S)

`endif

/* File: shared/ext_mon_pkg.sv */
// types of the monitor supervisor
package ext_mon_pkg;

	typedef enum logic [1:0] {
		QUAL_ALWAYS,
		QUAL_READY_RUN,
		QUAL_RUN_ONLY
	} qual_t;

	typedef enum logic [2:0] {
		RESP_IGNORE,
		RESP_FREEWHEEL,
		RESP_RAMP,
		RESP_FAST,
		RESP_DC_INJECT
	} resp_t;

	typedef enum {
		CH_IDLE,
		CH_TIMING,
		CH_FIRED
	} ch_state_t;

	typedef struct packed {
		logic [8:0] delay;
		resp_t resp;
		qual_t qual;
		logic [6:0] src;
	} ch_cfg_t;

	typedef struct packed {
		logic ready;
		logic run;
	} drive_state_t;

endpackage

/* File: core/ext_mon_supervisor.sv */
// four-channel external monitoring circuit supervisor with avalon-mm registers
// Operation
// - four identical channels A to D
// - each channel selects at most one source
// - high-level input or word bit: active one
// - low-level input: active zero
// - eight base, six extension inputs, both polarities
// - any sixteen bits of five control words
// - word bits 0-10 need I/O profile
// - always active qualifier ignores drive state
// - ready-and-run qualifier: ready or running
// - run-only qualifier: running only
// - delay 0 to 300 seconds, default zero
// - delay starts on qualifier and active source
// - warning level raises channel warning, no stop
// - error level raises channel error and stops
// - qualifier and delay only with source assigned
// - ignore response gives warning only
// - stopping responses stop drive, raise error
`timescale 1ns/100ps
`include "ext_mon_params.svh"

module ext_mon_supervisor #(
	parameter int unsigned TICK_CYCLES = `EM_TICK_CYCLES,
	parameter int unsigned CNT_W = 27
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [7:0] di_base_i,
	input wire logic [5:0] di_ext_i,
	input wire logic [4:0][15:0] ctrl_words_i,
	input wire ext_mon_pkg::drive_state_t drive_state_i,
	output logic [3:0] warn_o,
	output logic [3:0] err_o,
	output logic stop_o,
	output logic irq_o
);

	// ****************************************
	// elaboration checks
	// ****************************************
	if (TICK_CYCLES < 1 || TICK_CYCLES > (2 ** CNT_W)) begin : g_bad_tick
		$error("TICK_CYCLES does not fit the sub-second counter");
	end

	localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES - 1);

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [7:0] di_meta_ff;
	logic [7:0] di_ff;
	logic [5:0] ext_meta_ff;
	logic [5:0] ext_ff;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			di_meta_ff <= 8'h00;
			di_ff <= 8'h00;
			ext_meta_ff <= 6'h00;
			ext_ff <= 6'h00;
		end else begin
			di_meta_ff <= di_base_i;
			di_ff <= di_meta_ff;
			ext_meta_ff <= di_ext_i;
			ext_ff <= ext_meta_ff;
		end
	end

	// ****************************************
	// bus handshake
	// ****************************************
	logic wait_ff;
	logic [31:0] rdata_ff;
	logic req;
	logic wr_go;
	logic [31:0] rd_mux;

	assign req = avs_read_i | avs_write_i;
	// access completes at the edge where waitrequest is seen low
	assign wr_go = avs_write_i & ~wait_ff;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_ff <= 1'b1;
		end else if (req && wait_ff) begin
			wait_ff <= 1'b0;
		end else begin
			wait_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read_i && wait_ff) begin
			rdata_ff <= rd_mux;
		end
	end

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	logic [31:0] wmask;
	assign wmask = be_merge(32'h0000_0000, 32'hFFFF_FFFF, avs_byteenable_i);

	// ****************************************
	// global control and mask
	// ****************************************
	logic [1:0] ctrl_ff;
	logic [31:0] mask_ff;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_ff <= `EM_CTRL_RST;
		end else if (wr_go && avs_address_i == `EM_OFS_CTRL) begin
			ctrl_ff <= 2'(be_merge({30'h0, ctrl_ff}, avs_writedata_i, avs_byteenable_i));
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_ff <= `EM_MASK_RST;
		end else if (wr_go && avs_address_i == `EM_OFS_MASK) begin
			mask_ff <= be_merge(mask_ff, avs_writedata_i, avs_byteenable_i);
		end
	end

	// ****************************************
	// channels
	// ****************************************
	logic [3:0] act;
	logic [3:0] trig;
	logic [3:0] fired;
	logic [3:0] is_warn;
	logic [31:0] cfg_rd [4];

	for (genvar c = 0; c < 4; c++) begin : g_ch
		ext_mon_pkg::ch_cfg_t cfg_ff;
		ext_mon_pkg::ch_cfg_t nxt_cfg;
		ext_mon_pkg::ch_state_t st_ff;
		logic [CNT_W-1:0] sub_ff;
		logic [8:0] sec_ff;
		logic ev;
		logic qual_ok;
		logic [6:0] ofs;
		logic [31:0] merged;
		logic cfg_wr;
		logic [31:0] cfg_reg;

		assign cfg_wr = wr_go && avs_address_i == 6'(`EM_OFS_CH0 + 6'(c * 4));
		// register layout keeps the struct field order but pads between fields, so map field by field
		assign cfg_reg = {7'h00, cfg_ff.delay, 1'b0, cfg_ff.resp, 2'h0, cfg_ff.qual, 1'b0,
			cfg_ff.src};
		assign merged = be_merge(cfg_reg, avs_writedata_i, avs_byteenable_i);

		always_comb begin
			nxt_cfg = cfg_ff;
			nxt_cfg.src = merged[6:0];
			// qualifier, response and delay fields only take a write that also assigns a source
			if (merged[6:0] != `EM_SRC_NONE) begin
				nxt_cfg.qual = ext_mon_pkg::qual_t'(merged[9:8]);
				nxt_cfg.resp = ext_mon_pkg::resp_t'(merged[14:12]);
				nxt_cfg.delay = (merged[24:16] > `EM_DELAY_MAX) ? `EM_DELAY_MAX :
					merged[24:16];
			end
		end

		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				cfg_ff <= '{delay: 9'h000, resp: ext_mon_pkg::RESP_FREEWHEEL,
					qual: ext_mon_pkg::QUAL_ALWAYS, src: `EM_SRC_NONE};
			end else if (cfg_wr) begin
				cfg_ff <= nxt_cfg;
			end
		end

		assign cfg_rd[c] = (cfg_ff.src == `EM_SRC_NONE) ? {25'h0, cfg_ff.src} :
			cfg_reg;

		// source decode; selections the hardware cannot serve read as inactive
		always_comb begin
			ofs = 7'h00;
			ev = 1'b0;
			if (cfg_ff.src >= `EM_SRC_CW) begin
				ofs = cfg_ff.src - `EM_SRC_CW;
				if (ofs[6:4] < 3'h5 && (ofs[3:0] > `EM_CW_IO_ONLY_MAX ||
					ctrl_ff[`EM_CTRL_IO_PROFILE])) begin
					ev = ctrl_words_i[3'(ofs[6:4])][ofs[3:0]];
				end
			end else if (cfg_ff.src >= `EM_SRC_EXT_LO && cfg_ff.src < `EM_SRC_EXT_LO + 7'h06) begin
				ofs = cfg_ff.src - `EM_SRC_EXT_LO;
				ev = ctrl_ff[`EM_CTRL_EXT_FITTED] & ~ext_ff[3'(ofs)];
			end else if (cfg_ff.src >= `EM_SRC_DI_LO && cfg_ff.src < `EM_SRC_DI_LO + 7'h08) begin
				ofs = cfg_ff.src - `EM_SRC_DI_LO;
				ev = ~di_ff[3'(ofs)];
			end else if (cfg_ff.src >= `EM_SRC_EXT_HI && cfg_ff.src < `EM_SRC_EXT_HI + 7'h06) begin
				ofs = cfg_ff.src - `EM_SRC_EXT_HI;
				ev = ctrl_ff[`EM_CTRL_EXT_FITTED] & ext_ff[3'(ofs)];
			end else if (cfg_ff.src >= `EM_SRC_DI_HI && cfg_ff.src < `EM_SRC_DI_HI + 7'h08) begin
				ofs = cfg_ff.src - `EM_SRC_DI_HI;
				ev = di_ff[3'(ofs)];
			end
		end

		always_comb begin
			case (cfg_ff.qual)
				ext_mon_pkg::QUAL_READY_RUN: qual_ok = drive_state_i.ready |
					drive_state_i.run;
				ext_mon_pkg::QUAL_RUN_ONLY: qual_ok = drive_state_i.run;
				default: qual_ok = 1'b1;
			endcase
		end

		assign act[c] = ev & qual_ok & (cfg_ff.src != `EM_SRC_NONE);
		assign trig[c] = act[c] && st_ff != ext_mon_pkg::CH_FIRED && (cfg_ff.delay == 9'h000 ||
			(st_ff == ext_mon_pkg::CH_TIMING && sub_ff == TICK_LAST &&
			sec_ff + 9'h001 >= cfg_ff.delay));
		assign fired[c] = st_ff == ext_mon_pkg::CH_FIRED;
		assign is_warn[c] = cfg_ff.resp == ext_mon_pkg::RESP_IGNORE;

		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				st_ff <= ext_mon_pkg::CH_IDLE;
				sub_ff <= '0;
				sec_ff <= 9'h000;
			end else if (!act[c]) begin
				st_ff <= ext_mon_pkg::CH_IDLE;
				sub_ff <= '0;
				sec_ff <= 9'h000;
			end else if (trig[c]) begin
				st_ff <= ext_mon_pkg::CH_FIRED;
			end else begin
				case (st_ff)
					ext_mon_pkg::CH_IDLE: st_ff <= ext_mon_pkg::CH_TIMING;
					ext_mon_pkg::CH_TIMING: begin
						if (sub_ff == TICK_LAST) begin
							sub_ff <= '0;
							sec_ff <= sec_ff + 9'h001;
						end else begin
							sub_ff <= sub_ff + CNT_W'(1);
						end
					end
					default: st_ff <= st_ff;
				endcase
			end
		end

		unassigned_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
			cfg_ff.src == `EM_SRC_NONE |-> !trig[c] ##1 sec_ff == 9'h000)
			else $error("unassigned channel is timing or firing");
		abandon_delay_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
			!act[c] |=> st_ff == ext_mon_pkg::CH_IDLE && sub_ff == '0)
			else $error("pending delay not abandoned");
		zero_delay_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
			act[c] && cfg_ff.delay == 9'h000 && !fired[c] |-> trig[c])
			else $error("zero delay did not fire at once");
		no_early_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
			trig[c] && cfg_ff.delay != 9'h000 |-> sec_ff + 9'h001 >= cfg_ff.delay)
			else $error("channel fired before its delay");
		run_only_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
			cfg_ff.qual == ext_mon_pkg::QUAL_RUN_ONLY && !drive_state_i.run |-> !act[c])
			else $error("run-only channel monitored outside run");
		ready_run_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
			cfg_ff.qual == ext_mon_pkg::QUAL_READY_RUN && !drive_state_i.ready &&
			!drive_state_i.run |-> !act[c])
			else $error("ready-and-run channel monitored while stopped");
		io_only_bits_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
			cfg_ff.src >= `EM_SRC_CW && cfg_ff.src[3:0] <= `EM_CW_IO_ONLY_MAX &&
			!ctrl_ff[`EM_CTRL_IO_PROFILE] |-> !act[c])
			else $error("low word bit used outside the I/O profile");
		ext_fitted_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
			cfg_ff.src inside {[`EM_SRC_EXT_HI:`EM_SRC_EXT_HI + 7'h05],
			[`EM_SRC_EXT_LO:`EM_SRC_EXT_LO + 7'h05]} && !ctrl_ff[`EM_CTRL_EXT_FITTED] |-> !act[c])
			else $error("extension input used without the module fitted");
	end

	// ****************************************
	// sticky flags, status and interrupt
	// ****************************************
	logic [3:0] warn_ff;
	logic [3:0] err_ff;
	logic [3:0] warn_clr;
	logic [3:0] err_clr;
	logic stop_ff;
	logic irq_ff;

	assign warn_clr = (wr_go && avs_address_i == `EM_OFS_STATUS) ?
		avs_writedata_i[3:0] & wmask[3:0] : 4'h0;
	assign err_clr = (wr_go && avs_address_i == `EM_OFS_STATUS) ?
		avs_writedata_i[`EM_ERR_LSB +: 4] & wmask[`EM_ERR_LSB +: 4] : 4'h0;

	// a new event in the clearing cycle wins over the clear
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			warn_ff <= 4'h0;
			err_ff <= 4'h0;
		end else begin
			warn_ff <= (warn_ff & ~warn_clr) | (trig & is_warn);
			err_ff <= (err_ff & ~err_clr) | (trig & ~is_warn);
		end
	end

	// stop holds while any channel error is latched; software clears it to allow restart
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stop_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			stop_ff <= |err_ff;
			irq_ff <= |({20'h0, err_ff, 4'h0, warn_ff} & mask_ff);
		end
	end

	always_comb begin
		case (avs_address_i)
			`EM_OFS_CTRL: rd_mux = {30'h0, ctrl_ff};
			`EM_OFS_STATUS: rd_mux = {20'h0, err_ff, 4'h0, warn_ff};
			`EM_OFS_MASK: rd_mux = mask_ff;
			`EM_OFS_STATE: rd_mux = {15'h0, stop_ff, 4'h0, fired, 4'h0, act};
			`EM_OFS_CH0: rd_mux = cfg_rd[0];
			`EM_OFS_CH0 + 6'h04: rd_mux = cfg_rd[1];
			`EM_OFS_CH0 + 6'h08: rd_mux = cfg_rd[2];
			`EM_OFS_CH0 + 6'h0C: rd_mux = cfg_rd[3];
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	assign avs_readdata_o = rdata_ff;
	assign avs_waitrequest_o = wait_ff;
	assign warn_o = warn_ff;
	assign err_o = err_ff;
	assign stop_o = stop_ff;
	assign irq_o = irq_ff;

	// ****************************************
	// checks
	// ****************************************
	warn_raise_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(trig & is_warn) != 4'h0 |=> (warn_o & $past(trig & is_warn)) == $past(trig & is_warn)
		##1 !stop_o || $past(err_ff) != 4'h0)
		else $error("warning not raised or drive stopped");
	err_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(trig & ~is_warn) != 4'h0 |=> err_o != 4'h0 ##1 stop_o)
		else $error("error did not stop the drive");
	ignore_noerr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(trig & is_warn) != 4'h0 |=> (err_o & $past(trig & is_warn) & ~$past(err_ff)) == 4'h0)
		else $error("ignore response recorded an error");
	bus_answer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		req && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("slave did not answer within one cycle");
	irq_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		##1 irq_o == $past(|({20'h0, err_ff, 4'h0, warn_ff} & mask_ff)))
		else $error("interrupt does not follow masked status");

	fire_warn_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) (trig & is_warn) != 4'h0);
	fire_err_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(stop_o));
	abandon_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		g_ch[0].st_ff == ext_mon_pkg::CH_TIMING ##1 g_ch[0].st_ff == ext_mon_pkg::CH_IDLE);
	delay_fire_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		g_ch[0].sec_ff != 9'h000 && trig[0]);

endmodule // ext_mon_supervisor

/* File: tb/field_contacts.sv */
// behavioural model of the field contacts wired to the digital inputs
`timescale 1ns/100ps

module field_contacts (
	input wire logic [13:0] idle_i,
	input wire logic [13:0] trip_i,
	output logic [7:0] di_base_o,
	output logic [5:0] di_ext_o
);
	// a tripped circuit flips its contact away from its idle level, so the
	// bench can exercise both polarities of every pin
	assign {di_ext_o, di_base_o} = idle_i ^ trip_i;
endmodule // field_contacts

/* File: tb/testbench.sv */
// self-checking bench of the external monitor supervisor
`timescale 1ns/100ps
`include "ext_mon_params.svh"

module testbench;
	// short second so that delays of a few seconds stay cheap to simulate
	localparam int unsigned TICK = 4;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [5:0] addr = 6'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic wait_rq;
	logic [13:0] idle = 14'h0000;
	logic [13:0] trip = 14'h0000;
	logic [7:0] di_base;
	logic [5:0] di_ext;
	logic [4:0][15:0] cw = '0;
	ext_mon_pkg::drive_state_t ds = 2'h0;
	logic [3:0] warn;
	logic [3:0] err;
	logic stop;
	logic irq;
	logic [31:0] flags;
	logic [31:0] rv;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;

	assign flags = {24'h000000, err, warn};

	field_contacts i_contacts (
		.idle_i(idle),
		.trip_i(trip),
		.di_base_o(di_base),
		.di_ext_o(di_ext)
	);

	ext_mon_supervisor #(.TICK_CYCLES(TICK), .CNT_W(27)) i_dut (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.avs_address_i(addr),
		.avs_read_i(rd),
		.avs_write_i(wr),
		.avs_writedata_i(wdata),
		.avs_byteenable_i(4'hF),
		.avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_rq),
		.di_base_i(di_base),
		.di_ext_i(di_ext),
		.ctrl_words_i(cw),
		.drive_state_i(ds),
		.warn_o(warn),
		.err_o(err),
		.stop_o(stop),
		.irq_o(irq)
	);

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// holds the request until waitrequest is sampled low at a rising edge
	// only the global cycle ceiling ends a wait that never completes
	task automatic bus(input logic is_wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= is_wr;
		rd <= ~is_wr;
		do begin
			@(posedge clk_i);
		end while (wait_rq !== 1'b0);
		rv = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic expect_flags(input int lim, input logic [7:0] exp);
		int n;
		n = 0;
		while (flags[7:0] !== exp && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		check(flags, {24'h000000, exp});
	endtask

	function automatic logic [31:0] cfg(input logic [6:0] s, input logic [1:0] q,
		input logic [2:0] r, input logic [8:0] dl);
		return {7'h00, dl, 1'b0, r, 2'h0, q, 1'b0, s};
	endfunction

	task automatic clear_all();
		@(posedge clk_i);
		trip <= '0;
		cw <= '0;
		ds <= 2'h0;
		for (int c = 0; c < 4; c++) bus(1'b1, `EM_OFS_CH0 + 6'(4 * c), 32'h00000000);
		bus(1'b1, `EM_OFS_STATUS, 32'h00000F0F);
		bus(1'b1, `EM_OFS_CTRL, 32'h00000000);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		check({22'h000000, err, warn, stop, irq}, 32'h00000000);
		bus(1'b0, `EM_OFS_CH0, 32'h00000000);
		check(rv, 32'h00000000);
		bus(1'b0, 6'h3C, 32'h00000000);
		check(rv, 32'h00000000);
		bus(1'b0, 6'h02, 32'h00000000);
		check(rv, 32'h00000000);
	endtask

	task automatic t_cfg();
		bus(1'b1, `EM_OFS_CH0 + 6'h04, cfg(7'h00, 2'h2, 3'h3, 9'h005));
		bus(1'b0, `EM_OFS_CH0 + 6'h04, 32'h00000000);
		check(rv, 32'h00000000);
		cw <= 16'hFFFF;
		tick(6);
		check(flags, 32'h00000000);
		bus(1'b1, `EM_OFS_CH0 + 6'h04, cfg(7'h01, 2'h2, 3'h3, 9'h12D));
		bus(1'b0, `EM_OFS_CH0 + 6'h04, 32'h00000000);
		check(rv, cfg(7'h01, 2'h2, 3'h3, `EM_DELAY_MAX));
		clear_all();
	endtask

	// every stopping response, the first two with the interrupt masked out, the last two with it in
	task automatic t_err();
		for (int r = 1; r < 5; r++) begin
			bus(1'b1, `EM_OFS_MASK, (r > 2) ? 32'h00000F0F : 32'h00000000);
			bus(1'b1, `EM_OFS_CH0, cfg(7'h2C, 2'h0, 3'(r), 9'h000));
			cw[0][12] <= 1'b1;
			expect_flags(6, 8'h10);
			tick(2);
			check({31'h00000000, stop}, 32'h00000001);
			check({31'h00000000, irq}, {31'h00000000, r > 2});
			cw <= '0;
			bus(1'b1, `EM_OFS_STATUS, 32'h00000100);
			tick(2);
			check({30'h00000000, stop, irq}, 32'h00000000);
		end
		bus(1'b1, `EM_OFS_MASK, 32'h00000000);
		clear_all();
	endtask

	task automatic t_warn();
		bus(1'b1, `EM_OFS_CH0 + 6'h04, cfg(7'h03, 2'h0, 3'h0, 9'h001));
		trip[2] <= 1'b1;
		tick(4);
		check(flags, 32'h00000000);
		expect_flags(10, 8'h02);
		tick(2);
		check({31'h00000000, stop}, 32'h00000000);
		clear_all();
	endtask

	task automatic t_low();
		@(posedge clk_i);
		idle <= 14'h3FFF;
		bus(1'b1, `EM_OFS_CH0 + 6'h08, cfg(7'h12, 2'h0, 3'h0, 9'h000));
		bus(1'b1, `EM_OFS_CH0 + 6'h0C, cfg(7'h1B, 2'h0, 3'h0, 9'h000));
		tick(4);
		check(flags, 32'h00000000);
		trip[1] <= 1'b1;
		trip[10] <= 1'b1;
		expect_flags(8, 8'h04);
		tick(4);
		check(flags, 32'h00000004);
		bus(1'b1, `EM_OFS_CTRL, 32'h00000002);
		expect_flags(8, 8'h0C);
		clear_all();
		idle <= 14'h0000;
	endtask

	task automatic t_qual();
		for (int q = 2; q >= 0; q--) begin
			bus(1'b1, `EM_OFS_CH0 + 6'h0C, cfg(7'h6F, 2'(q), 3'h0, 9'h000));
			ds <= (q == 2) ? 2'h2 : 2'h0;
			cw[4][15] <= 1'b1;
			tick(6);
			check(flags, (q == 0) ? 32'h00000008 : 32'h00000000);
			ds <= (q == 1) ? 2'h2 : 2'h1;
			expect_flags(8, 8'h08);
			clear_all();
		end
	endtask

	task automatic t_profile();
		bus(1'b1, `EM_OFS_CH0, cfg(7'h33, 2'h0, 3'h0, 9'h000));
		bus(1'b1, `EM_OFS_CH0 + 6'h04, cfg(7'h3B, 2'h0, 3'h0, 9'h000));
		cw[1] <= 16'h0808;
		tick(6);
		check(flags, 32'h00000002);
		bus(1'b1, `EM_OFS_CTRL, 32'h00000001);
		expect_flags(6, 8'h03);
		clear_all();
	endtask

	task automatic t_abandon();
		bus(1'b1, `EM_OFS_CH0, cfg(7'h01, 2'h0, 3'h1, 9'h002));
		trip[0] <= 1'b1;
		tick(6);
		trip[0] <= 1'b0;
		tick(12);
		check(flags, 32'h00000000);
		trip[0] <= 1'b1;
		expect_flags(16, 8'h10);
		clear_all();
	endtask

	// ****************************************
	// run
	// ****************************************
	task automatic tally_and_finish();
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// the whole sequence needs a few hundred cycles; this only catches a hang
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_cfg();
		t_err();
		t_warn();
		t_low();
		t_qual();
		t_profile();
		t_abandon();
		tally_and_finish();
	end
endmodule // testbench
